// [include/bus_ctrl_pkg.sv]
// Purpose: shared constants and types of the bus command controller
// Assumes: 200 MHz system clock
// Notes: status codes as printed, msb first
package bus_ctrl_pkg;

    // ------------------------------------------------------------
    // status codes
    // ------------------------------------------------------------
    localparam logic [2:0] ST_INT_ACK = 3'h0;
    localparam logic [2:0] ST_IO_READ = 3'h1;
    localparam logic [2:0] ST_IO_WRITE = 3'h2;
    localparam logic [2:0] ST_HALT = 3'h3;
    localparam logic [2:0] ST_CODE_READ = 3'h4;
    localparam logic [2:0] ST_MEM_READ = 3'h5;
    localparam logic [2:0] ST_MEM_WRITE = 3'h6;
    localparam logic [2:0] ST_PASSIVE = 3'h7;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int GRANT_DELAY_NS = 85;
    localparam int GRANT_CNT_W = 5;
    localparam logic [GRANT_CNT_W-1:0] GRANT_CYCLES =
        GRANT_CNT_W'((GRANT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    // order: cpu clock, status[2:0], qualifier, strap, grant_n
    localparam int PIN_W = 7;
    localparam logic [PIN_W-1:0] PIN_RESET = 7'h39;
    localparam logic CMD_IDLE = 1'h1;
    localparam logic DIR_IDLE = 1'h1;

    // ------------------------------------------------------------
    // machine cycle phases
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        PH_IDLE = 5'h01,
        PH_STROBE = 5'h02,
        PH_ADDR = 5'h04,
        PH_EARLY = 5'h08,
        PH_LATE = 5'h10
    } phase_t;

    // receive direction cycles
    function automatic logic is_read(input logic [2:0] code);
        is_read = (code == ST_INT_ACK) || (code == ST_IO_READ) ||
                  (code == ST_CODE_READ) || (code == ST_MEM_READ);
    endfunction : is_read

    // memory space cycles
    function automatic logic is_mem(input logic [2:0] code);
        is_mem = code[2] && (code != ST_PASSIVE);
    endfunction : is_mem

endpackage : bus_ctrl_pkg

// [core/pin_sync.sv]
// Purpose: three stage pin synchroniser with agreement filter
// Assumes: inputs asynchronous to sys_clk_in
// Notes: output follows once stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic [WIDTH-1:0] pins_in,
    output logic [WIDTH-1:0] pins_out
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_out;

    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            next_out[i] = (stage2[i] == stage3[i]) ? stage3[i] : pins_out[i];
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            stage1 <= RESET_VAL;
            stage2 <= RESET_VAL;
            stage3 <= RESET_VAL;
            pins_out <= RESET_VAL;
        end else begin
            stage1 <= pins_in;
            stage2 <= stage1;
            stage3 <= stage2;
            pins_out <= next_out;
        end
    end

endmodule : pin_sync

// [core/cpu_bus_command_controller.sv]
// Purpose: status decoder and command/control generator
// Assumes: processor clock far slower than sys_clk_in
// Notes: all pins filtered, all outputs registered
// Function
// - early write commands assert one processor clock before normal writes
// - interrupt acknowledge uses the same timing as an io read
// - data enable gates the transceivers onto the local bus
// - direction output high for writes, low for reads
// - strap high: shared pin is active low peripheral data enable
// - strap low: shared pin is cascade enable, only in acknowledge cycles
// - acknowledge comes as two cycles, first one transfers nothing
// - cascade enable asserted with the strobe before second acknowledge
// - address strobe pulses once in every machine cycle
// - each strobe latches the status for halt decoding
// - qualifier high lets commands run normally
// - qualifier low drives every command line inactive
// - strobe starts at later of clock fall and status active
// - decode status codes into read, write and acknowledge commands
// - strap high: io commands and acknowledge ignore bus grant
// - strap low: no command until 85 ns after grant goes low
`timescale 1ns/1ps
module cpu_bus_command_controller (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic cpu_clk_in,
    input wire logic [2:0] cpu_status_in,
    input wire logic cmd_qualifier_in,
    input wire logic io_bus_strap_in,
    input wire logic bus_grant_n_in,
    output logic mem_read_cmd_n_out,
    output logic mem_write_cmd_n_out,
    output logic io_read_cmd_n_out,
    output logic io_write_cmd_n_out,
    output logic early_mem_write_cmd_n_out,
    output logic early_io_write_cmd_n_out,
    output logic int_ack_cmd_n_out,
    output logic addr_latch_strobe_out,
    output logic data_enable_out,
    output logic xfer_direction_out,
    output logic cascade_periph_data_enable_n_out
);

    // ------------------------------------------------------------
    // input filtering
    // ------------------------------------------------------------
    logic [bus_ctrl_pkg::PIN_W-1:0] pins;
    logic cpu_clk;
    logic [2:0] status;
    logic qual;
    logic strap;
    logic grant_n;

    pin_sync #(
        .WIDTH(bus_ctrl_pkg::PIN_W),
        .RESET_VAL(bus_ctrl_pkg::PIN_RESET)
    ) u_sync (
        .sys_clk_in(sys_clk_in),
        .nrst_in(nrst_in),
        .pins_in({cpu_clk_in, cpu_status_in, cmd_qualifier_in,
                  io_bus_strap_in, bus_grant_n_in}),
        .pins_out(pins)
    );

    assign {cpu_clk, status, qual, strap, grant_n} = pins;

    // ------------------------------------------------------------
    // bus grant delay
    // ------------------------------------------------------------
    logic [bus_ctrl_pkg::GRANT_CNT_W-1:0] grant_cnt;
    logic [bus_ctrl_pkg::GRANT_CNT_W-1:0] next_grant_cnt;
    logic grant_ok;

    always_comb begin
        next_grant_cnt = grant_cnt;
        if (grant_n) begin
            next_grant_cnt = '0;
        end else if (grant_cnt != bus_ctrl_pkg::GRANT_CYCLES) begin
            next_grant_cnt = grant_cnt + 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            grant_cnt <= '0;
        end else begin
            grant_cnt <= next_grant_cnt;
        end
    end

    assign grant_ok = !grant_n && (grant_cnt == bus_ctrl_pkg::GRANT_CYCLES);

    // ------------------------------------------------------------
    // machine cycle sequencer
    // ------------------------------------------------------------
    bus_ctrl_pkg::phase_t phase;
    bus_ctrl_pkg::phase_t next_phase;
    logic [2:0] lat_status;
    logic [2:0] next_lat_status;
    logic clk_prev;
    logic clk_fall;
    logic clk_rise;
    logic active;

    assign clk_fall = clk_prev && !cpu_clk;
    assign clk_rise = !clk_prev && cpu_clk;
    assign active = (status != bus_ctrl_pkg::ST_PASSIVE);

    always_comb begin
        next_phase = phase;
        next_lat_status = lat_status;
        case (phase)
            bus_ctrl_pkg::PH_IDLE: begin
                if (active && !cpu_clk) begin
                    next_phase = bus_ctrl_pkg::PH_STROBE;
                    next_lat_status = status;
                end
            end
            bus_ctrl_pkg::PH_STROBE: begin
                if (clk_rise) begin
                    next_phase = bus_ctrl_pkg::PH_ADDR;
                end
            end
            bus_ctrl_pkg::PH_ADDR: begin
                if (clk_fall && lat_status != bus_ctrl_pkg::ST_HALT) begin
                    next_phase = bus_ctrl_pkg::PH_EARLY;
                end
            end
            bus_ctrl_pkg::PH_EARLY: begin
                if (clk_fall) begin
                    next_phase = bus_ctrl_pkg::PH_LATE;
                end
            end
            default: begin
                next_phase = phase;
            end
        endcase
        if (phase != bus_ctrl_pkg::PH_IDLE &&
            phase != bus_ctrl_pkg::PH_STROBE && !active) begin
            next_phase = bus_ctrl_pkg::PH_IDLE;
            next_lat_status = bus_ctrl_pkg::ST_PASSIVE;
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            phase <= bus_ctrl_pkg::PH_IDLE;
            lat_status <= bus_ctrl_pkg::ST_PASSIVE;
            clk_prev <= 1'b0;
        end else begin
            phase <= next_phase;
            lat_status <= next_lat_status;
            clk_prev <= cpu_clk;
        end
    end

    // ------------------------------------------------------------
    // command and control outputs
    // ------------------------------------------------------------
    logic cmd_phase;
    logic late_phase;
    logic mem_ok;
    logic io_ok;
    logic next_mem_rd;
    logic next_mem_wr;
    logic next_io_rd;
    logic next_io_wr;
    logic next_early_mem;
    logic next_early_io;
    logic next_int_ack;
    logic next_strobe;
    logic next_den;
    logic next_dir;
    logic next_shared;

    always_comb begin
        cmd_phase = (phase == bus_ctrl_pkg::PH_EARLY) ||
                    (phase == bus_ctrl_pkg::PH_LATE);
        late_phase = (phase == bus_ctrl_pkg::PH_LATE);
        mem_ok = qual && grant_ok;
        io_ok = qual && (strap || grant_ok);
        next_mem_rd = cmd_phase && mem_ok &&
            (lat_status == bus_ctrl_pkg::ST_MEM_READ ||
             lat_status == bus_ctrl_pkg::ST_CODE_READ);
        next_early_mem = cmd_phase && mem_ok &&
            (lat_status == bus_ctrl_pkg::ST_MEM_WRITE);
        next_mem_wr = late_phase && mem_ok &&
            (lat_status == bus_ctrl_pkg::ST_MEM_WRITE);
        next_io_rd = cmd_phase && io_ok &&
            (lat_status == bus_ctrl_pkg::ST_IO_READ);
        next_early_io = cmd_phase && io_ok &&
            (lat_status == bus_ctrl_pkg::ST_IO_WRITE);
        next_io_wr = late_phase && io_ok &&
            (lat_status == bus_ctrl_pkg::ST_IO_WRITE);
        next_int_ack = cmd_phase && io_ok &&
            (lat_status == bus_ctrl_pkg::ST_INT_ACK);
        next_strobe = (phase == bus_ctrl_pkg::PH_STROBE);
        next_den = cmd_phase && qual &&
            ((bus_ctrl_pkg::is_mem(lat_status) && mem_ok) ||
             (!strap && !bus_ctrl_pkg::is_mem(lat_status) &&
              lat_status != bus_ctrl_pkg::ST_HALT && io_ok));
        next_dir = !((phase != bus_ctrl_pkg::PH_IDLE) &&
                     bus_ctrl_pkg::is_read(lat_status));
        if (strap) begin
            next_shared = !(cmd_phase && io_ok &&
                !bus_ctrl_pkg::is_mem(lat_status) &&
                lat_status != bus_ctrl_pkg::ST_HALT);
        end else begin
            next_shared = next_strobe &&
                (lat_status == bus_ctrl_pkg::ST_INT_ACK);
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mem_read_cmd_n_out <= bus_ctrl_pkg::CMD_IDLE;
            mem_write_cmd_n_out <= bus_ctrl_pkg::CMD_IDLE;
            io_read_cmd_n_out <= bus_ctrl_pkg::CMD_IDLE;
            io_write_cmd_n_out <= bus_ctrl_pkg::CMD_IDLE;
            early_mem_write_cmd_n_out <= bus_ctrl_pkg::CMD_IDLE;
            early_io_write_cmd_n_out <= bus_ctrl_pkg::CMD_IDLE;
            int_ack_cmd_n_out <= bus_ctrl_pkg::CMD_IDLE;
            addr_latch_strobe_out <= 1'b0;
            data_enable_out <= 1'b0;
            xfer_direction_out <= bus_ctrl_pkg::DIR_IDLE;
            cascade_periph_data_enable_n_out <= 1'b0;
        end else begin
            mem_read_cmd_n_out <= !next_mem_rd;
            mem_write_cmd_n_out <= !next_mem_wr;
            io_read_cmd_n_out <= !next_io_rd;
            io_write_cmd_n_out <= !next_io_wr;
            early_mem_write_cmd_n_out <= !next_early_mem;
            early_io_write_cmd_n_out <= !next_early_io;
            int_ack_cmd_n_out <= !next_int_ack;
            addr_latch_strobe_out <= next_strobe;
            data_enable_out <= next_den;
            xfer_direction_out <= next_dir;
            cascade_periph_data_enable_n_out <= next_shared;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!nrst_in);

    sequence seq_cmds_idle;
        mem_read_cmd_n_out && mem_write_cmd_n_out && io_read_cmd_n_out &&
        io_write_cmd_n_out && early_mem_write_cmd_n_out &&
        early_io_write_cmd_n_out && int_ack_cmd_n_out;
    endsequence

    sequence seq_end_cycle;
        phase == bus_ctrl_pkg::PH_IDLE ##1 seq_cmds_idle;
    endsequence

    AST_EARLY_FIRST: assert property (
        $fell(mem_write_cmd_n_out) |-> !early_mem_write_cmd_n_out &&
        $past(!early_mem_write_cmd_n_out))
        else $error("normal write before early write");
    AST_ACK_READ_DIR: assert property (
        !int_ack_cmd_n_out |-> !xfer_direction_out)
        else $error("acknowledge without receive direction");
    AST_WRITE_DIR: assert property (
        (!mem_write_cmd_n_out || !io_write_cmd_n_out) |-> xfer_direction_out)
        else $error("write without transmit direction");
    AST_CASCADE_ACK: assert property (
        $past(!strap) && cascade_periph_data_enable_n_out |->
        addr_latch_strobe_out && lat_status == bus_ctrl_pkg::ST_INT_ACK)
        else $error("cascade enable outside acknowledge strobe");
    AST_STROBE_START: assert property (
        phase == bus_ctrl_pkg::PH_IDLE && active && !cpu_clk |=>
        phase == bus_ctrl_pkg::PH_STROBE ##1 addr_latch_strobe_out)
        else $error("strobe not started");
    AST_HALT_HOLD: assert property (
        phase == bus_ctrl_pkg::PH_ADDR &&
        lat_status == bus_ctrl_pkg::ST_HALT |=> !cmd_phase)
        else $error("command issued in halt");
    AST_QUAL_OFF: assert property (
        !qual |=> seq_cmds_idle and !data_enable_out)
        else $error("command active with qualifier low");
    AST_GRANT_WAIT: assert property (
        $past(!strap) && !io_read_cmd_n_out |->
        $past(grant_cnt) == bus_ctrl_pkg::GRANT_CYCLES)
        else $error("command before grant delay");
    AST_PASSIVE_END: assert property (
        cmd_phase && !active |=> seq_end_cycle)
        else $error("cycle not ended on passive status");

endmodule : cpu_bus_command_controller

// [test/cpu_side_model.sv]
// Purpose: processor side model, clock and status lines
// Assumes: cpu clock period of 20 sys clocks, free running
// Notes: status held four cpu clocks, then passive for one before busy drops
`timescale 1ns/1ps
module cpu_side_model (
    input wire logic sys_clk_in,
    input wire logic start_in,
    input wire logic [2:0] code_in,
    output logic cpu_clk_out,
    output logic [2:0] cpu_status_out,
    output logic busy_out
);
    // ------------------------------------------------------------
    // clock divider and machine cycle sequencer
    // ------------------------------------------------------------
    int div = 0;
    int cnt = 0;
    logic pend = 1'h0;
    initial begin
        cpu_clk_out = 1'h1;
        cpu_status_out = 3'h7;
        busy_out = 1'h0;
    end
    always @(negedge sys_clk_in) begin
        div <= (div == 19) ? 0 : div + 1;
        if (start_in && !busy_out) begin
            pend <= 1'h1;
            busy_out <= 1'h1;
        end
        if (div == 9) begin
            cpu_clk_out <= 1'h0;
        end
        if (div == 19) begin
            cpu_clk_out <= 1'h1;
            if (pend) begin
                cpu_status_out <= code_in;
                pend <= 1'h0;
                cnt <= 1;
            end else if (cnt == 4) begin
                cpu_status_out <= 3'h7;
                cnt <= 5;
            end else if (cnt == 5) begin
                busy_out <= 1'h0;
                cnt <= 0;
            end else if (cnt != 0) begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule : cpu_side_model

// [test/cpu_bus_command_controller_bench.sv]
// Purpose: self-checking bench of the bus command controller
// Assumes: grant low and qualifier high unless a test says otherwise
// Notes: rows cover codes 0 to 6 with strap low, and 0, 1, 2, 5 and 6 with strap high
`timescale 1ns/1ps
module cpu_bus_command_controller_bench;
    typedef struct packed {
        logic [2:0] code;
        logic strap;
        logic [6:0] mask;
        logic dir_low;
        logic data_enable;
        logic [1:0] n_cp;
    } row_t;
    localparam row_t ROWS [12] = '{
        '{3'h0, 1'h0, 7'h01, 1'h1, 1'h1, 2'h1},
        '{3'h1, 1'h0, 7'h10, 1'h1, 1'h1, 2'h0},
        '{3'h2, 1'h0, 7'h0a, 1'h0, 1'h1, 2'h0},
        '{3'h3, 1'h0, 7'h00, 1'h0, 1'h0, 2'h0},
        '{3'h4, 1'h0, 7'h40, 1'h1, 1'h1, 2'h0},
        '{3'h5, 1'h0, 7'h40, 1'h1, 1'h1, 2'h0},
        '{3'h6, 1'h0, 7'h24, 1'h0, 1'h1, 2'h0},
        '{3'h0, 1'h1, 7'h01, 1'h1, 1'h0, 2'h1},
        '{3'h1, 1'h1, 7'h10, 1'h1, 1'h0, 2'h1},
        '{3'h2, 1'h1, 7'h0a, 1'h0, 1'h0, 2'h1},
        '{3'h5, 1'h1, 7'h40, 1'h1, 1'h1, 2'h0},
        '{3'h6, 1'h1, 7'h24, 1'h0, 1'h1, 2'h0}};
    logic sys_clk, nrst, qual, strap, grant_n, start, clr, cpu_clk, busy;
    logic strobe, data_enable, dir, cpden, cp_act, cp_q, strobe_q, dir_low, den_seen;
    logic vec_drive, vec_q, cp_masked, mcp_q, ack_second;
    logic [2:0] code, status;
    logic [6:0] cmd_n;
    int cyc, n_strobe, n_cp, t_strobe, t_grant, bad_count, n_tests, d_ack;
    int t_cmd [7];
    int n_vec, n_mcp;
    assign cp_act = strap ? ~cpden : cpden;
    // interrupt controller stand-in: vector driven in second acknowledge
    assign vec_drive = !cmd_n[0] && ack_second;
    // system logic masks cascade enable in the first acknowledge
    assign cp_masked = cp_act && !strap && ack_second;

    cpu_side_model cpu (
        .sys_clk_in(sys_clk),
        .start_in(start),
        .code_in(code),
        .cpu_clk_out(cpu_clk),
        .cpu_status_out(status),
        .busy_out(busy)
    );
    cpu_bus_command_controller DUT (
        .sys_clk_in(sys_clk),
        .nrst_in(nrst),
        .cpu_clk_in(cpu_clk),
        .cpu_status_in(status),
        .cmd_qualifier_in(qual),
        .io_bus_strap_in(strap),
        .bus_grant_n_in(grant_n),
        .mem_read_cmd_n_out(cmd_n[6]),
        .mem_write_cmd_n_out(cmd_n[5]),
        .io_read_cmd_n_out(cmd_n[4]),
        .io_write_cmd_n_out(cmd_n[3]),
        .early_mem_write_cmd_n_out(cmd_n[2]),
        .early_io_write_cmd_n_out(cmd_n[1]),
        .int_ack_cmd_n_out(cmd_n[0]),
        .addr_latch_strobe_out(strobe),
        .data_enable_out(data_enable),
        .xfer_direction_out(dir),
        .cascade_periph_data_enable_n_out(cpden)
    );
    // ------------------------------------------------------------
    // output monitor
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        strobe_q <= strobe;
        cp_q <= cp_act;
        vec_q <= vec_drive;
        mcp_q <= cp_masked;
        if (grant_n) t_grant <= cyc;
        if (clr) begin
            n_strobe <= 0;
            n_cp <= 0;
            n_vec <= 0;
            n_mcp <= 0;
            t_strobe <= -1;
            dir_low <= 1'h0;
            den_seen <= 1'h0;
            for (int i = 0; i < 7; i++) t_cmd[i] <= -1;
        end else begin
            if (strobe && !strobe_q) n_strobe <= n_strobe + 1;
            if (strobe && !strobe_q && t_strobe < 0) t_strobe <= cyc;
            if (cp_act && !cp_q) n_cp <= n_cp + 1;
            if (vec_drive && !vec_q) n_vec <= n_vec + 1;
            if (cp_masked && !mcp_q) n_mcp <= n_mcp + 1;
            if (!dir) dir_low <= 1'h1;
            if (data_enable) den_seen <= 1'h1;
            for (int i = 0; i < 7; i++)
                if (!cmd_n[i] && t_cmd[i] < 0) t_cmd[i] <= cyc;
        end
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check_vec(input logic [6:0] got, input logic [6:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check_vec
    task automatic check_int(input int got, input int exp);
        n_tests++;
        if (got != exp) begin
            bad_count++;
            $display("[ERR] %0t got %0d expected %0d", $time, got, exp);
        end
    endtask : check_int
    function automatic logic [6:0] seen_mask();
        for (int i = 0; i < 7; i++) seen_mask[i] = (t_cmd[i] >= 0);
    endfunction : seen_mask
    task automatic setup(input logic s, input logic q, input logic g);
        @(negedge sys_clk);
        strap = s;
        qual = q;
        grant_n = g;
        repeat (10) @(negedge sys_clk);
    endtask : setup
    task automatic run_cycle(input logic [2:0] c, input logic keep);
        int k;
        @(negedge sys_clk);
        clr <= !keep;
        code <= c;
        start <= 1'h1;
        @(negedge sys_clk);
        clr <= 1'h0;
        for (k = 0; k < 50 && busy !== 1'h1; k++) @(negedge sys_clk);
        if (busy !== 1'h1) begin
            bad_count++;
            $display("[ERR] %0t cycle did not start", $time);
        end
        start <= 1'h0;
        for (k = 0; k < 400 && busy !== 1'h0; k++) @(negedge sys_clk);
        if (busy !== 1'h0) begin
            bad_count++;
            $display("[ERR] %0t cycle did not finish", $time);
        end
        repeat (20) @(negedge sys_clk);
    endtask : run_cycle
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop
    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'h0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial begin
        #100000;
        bad_count++;
        $display("[ERR] %0t watchdog expired", $time);
        report_and_stop();
    end
    initial begin
        {nrst, qual, strap, grant_n, start, clr, code} = 9'h047;
        {bad_count, n_tests, cyc, d_ack} = '0;
        ack_second = 1'h0;
        repeat (3) @(negedge sys_clk);
        check_vec({strobe, data_enable, dir, cpden, 3'h0}, 7'h10);
        check_vec(cmd_n, 7'h7f);
        repeat (2) @(negedge sys_clk);
        nrst = 1'h1;
        for (int i = 0; i < 12; i++) begin
            setup(ROWS[i].strap, 1'h1, 1'h0);
            run_cycle(ROWS[i].code, 1'h0);
            check_vec(seen_mask(), ROWS[i].mask);
            check_vec({6'h0, dir_low}, {6'h0, ROWS[i].dir_low});
            check_vec({6'h0, den_seen}, {6'h0, ROWS[i].data_enable});
            check_int(n_cp, ROWS[i].n_cp);
            check_int(n_strobe, 1);
            check_vec({strobe, data_enable, cmd_n[4:0]}, 7'h1f);
            if (ROWS[i].mask[5]) check_int(t_cmd[2] < t_cmd[5], 1);
            if (ROWS[i].mask[3]) check_int(t_cmd[1] < t_cmd[3], 1);
            if (i == 0) d_ack = t_cmd[0] - t_strobe;
            if (i == 1) check_int(t_cmd[4] - t_strobe, d_ack);
            if (i == 2) check_int(t_cmd[1] - t_strobe, d_ack);
            $display("row %0d done", i);
        end
        setup(1'h0, 1'h1, 1'h0);
        run_cycle(3'h0, 1'h0);
        ack_second = 1'h1;
        run_cycle(3'h0, 1'h1);
        ack_second = 1'h0;
        check_int(n_strobe, 2);
        check_int(n_cp, 2);
        check_int(n_mcp, 1);
        check_int(n_vec, 1);
        $display("acknowledge pair test done");
        setup(1'h1, 1'h0, 1'h0);
        run_cycle(3'h1, 1'h0);
        check_vec({seen_mask()}, 7'h00);
        check_int(n_cp + n_strobe, 1);
        setup(1'h0, 1'h0, 1'h0);
        run_cycle(3'h5, 1'h0);
        check_vec({seen_mask() | {6'h0, den_seen}}, 7'h00);
        $display("qualifier test done");
        setup(1'h0, 1'h1, 1'h1);
        run_cycle(3'h1, 1'h0);
        check_vec(seen_mask(), 7'h00);
        setup(1'h1, 1'h1, 1'h1);
        run_cycle(3'h1, 1'h0);
        check_vec(seen_mask(), 7'h10);
        run_cycle(3'h5, 1'h0);
        check_vec(seen_mask(), 7'h00);
        setup(1'h0, 1'h1, 1'h1);
        fork
            run_cycle(3'h1, 1'h0);
            begin
                @(posedge strobe);
                @(negedge sys_clk);
                grant_n = 1'h0;
            end
        join
        check_int(t_cmd[4] - t_grant >= 17, 1);
        check_int(t_cmd[4] - t_grant <= 26, 1);
        $display("grant test done");
        setup(1'h0, 1'h1, 1'h0);
        fork
            run_cycle(3'h5, 1'h0);
            begin
                wait (cmd_n[6] === 1'h0);
                @(negedge sys_clk);
                nrst = 1'h0;
                @(negedge sys_clk);
                check_vec(cmd_n, 7'h7f);
                check_vec({strobe, data_enable, dir, cpden, 3'h0}, 7'h10);
                repeat (4) @(negedge sys_clk);
                nrst = 1'h1;
            end
        join
        setup(1'h0, 1'h1, 1'h0);
        run_cycle(3'h5, 1'h0);
        check_vec(seen_mask(), 7'h40);
        check_int(n_strobe, 1);
        $display("reset test done");
        report_and_stop();
    end
endmodule : cpu_bus_command_controller_bench
